// ### core/hdsc_pkg.sv
// Package of addresses, control bit layout and types for the host/processor shared control block.
package hdsc_pkg;

  // ==========================================================================
  // Host I/O map (10-bit I/O decode).
  localparam logic [9:0] HOST_SEM_BASE = 10'h330;
  localparam logic [9:0] HOST_SEM_LAST = 10'h337;
  localparam logic [9:0] HOST_MAP_ADDR = 10'h338;
  localparam logic [9:0] HOST_CTRL_ADDR = 10'h339;

  // ==========================================================================
  // Host memory window: one 4 K-byte page selected by address bits 19..12.
  localparam int WIN_PAGE_LSB = 12;
  localparam int WIN_PAGE_MSB = 19;

  // ==========================================================================
  // Processor expansion bus map (24-bit word addresses).
  localparam logic [23:0] DSP_CTRL_ADDR = 24'h80_5ff7;
  localparam logic [23:0] DSP_SEM_BASE = 24'h80_5ff8;
  localparam logic [23:0] DSP_SEM_LAST = 24'h80_5fff;
  localparam logic [23:0] DSP_MEM_BASE = 24'h80_4000;
  localparam logic [23:0] DSP_MEM_LAST = 24'h80_4fff;

  // ==========================================================================
  // Processor primary bus: low boot range and high SRAM range.
  localparam logic [23:0] PRIM_LOW_BASE = 24'h00_0000;
  localparam logic [23:0] PRIM_LOW_LAST = 24'h00_3fff;
  localparam logic [23:0] PRIM_HIGH_BASE = 24'hf0_0000;
  localparam logic [23:0] PRIM_HIGH_LAST = 24'hf0_3fff;

  // ==========================================================================
  // Control register layout and reset values.
  localparam logic [7:0] CTRL_SWAP_MASK = 8'h80;
  localparam logic [7:0] CTRL_BANK_MASK = 8'h40;
  localparam logic [7:0] CTRL_HOST_MASK = 8'h0f;
  localparam logic [7:0] CTRL_DSP_MASK = 8'hf0;
  localparam logic [3:0] NIBBLE_RESET = 4'h0;
  localparam logic [7:0] MAP_RESET = 8'h00;
  localparam logic [7:0] SEM_RESET = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;

  typedef struct packed {
    logic memSwap;
    logic bankSelect;
    logic hostToDspIrqArm;
    logic dspToHostIrq;
    logic boardSoftResetN;
    logic windowEnable;
    logic dspToHostIrqArm;
    logic hostToDspIrq;
  } hdsc_ctrl_t;

  typedef struct packed {
    logic [9:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } hdsc_host_io_t;

  typedef struct packed {
    logic [23:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } hdsc_dsp_io_t;

endpackage

// ### core/hdsc_shared_control.sv
// Host/processor shared control: window mapping, split control register, semaphores and decodes.
// Function
// - Host memory access matches window map against host address bits 12..19.
// - Window sits on any 4 K-byte page within the lowest 1 M-byte.
// - Window enable bit 2 gates whether the shared SRAM decodes in host space.
// - Host writes control bits 3..0, processor writes bits 7..4; both read all.
// - Host reset clears lower nibble; processor reset clears upper nibble.
// - Host sets bit 0 to assert processor interrupt input zero.
// - Processor bit 5 low suppresses and clears the host-to-processor interrupt.
// - Processor sets bit 4 to raise the host interrupt request.
// - Host bit 1 low blocks and clears the processor-to-host interrupt.
// - Bit 3 low holds the board in soft reset; reads 0 after power-on.
// - Bit 6 drives the upper expansion SRAM address line, selecting the 4 K-word half.
// - Bit 7 swaps boot and SRAM bank 0 ranges on the primary bus.
// - Eight semaphores at host I/O 0330..0337, only the LSB holds state.
// - Window map at host I/O 0338 (write only), control at 0339.
// - Semaphores never gate shared memory accesses.
// - Processor sees control at 0x00805FF7, swap mask 0x80, bank mask 0x40.
// - Processor decodes memory at 0x00804000..0x00804FFF, semaphores at 0x00805FF8..FFF.
`timescale 1ns/1ps

module hdsc_shared_control
  import hdsc_pkg::*;
(
  // Clock and resets.
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic hostResetIn,
  input wire logic dspResetIn,
  // Host I/O port.
  input wire hdsc_host_io_t hostIo,
  output logic [7:0] hostIoRdata,
  // Host memory decode.
  input wire logic hostMemReq,
  input wire logic [19:0] hostMemAddr,
  output logic hostWindowSelect,
  // Processor expansion bus.
  input wire hdsc_dsp_io_t dspIo,
  output logic [7:0] dspIoRdata,
  output logic dspMemSelect,
  // Processor primary bus decode.
  input wire logic [23:0] primAddr,
  output logic bootRomSelect,
  output logic sramBank0Select,
  // Control outputs.
  output logic processorIrqInputZero,
  output logic hostIrqRequest,
  output logic boardSoftResetN,
  output logic expSramHighAddr
);

  // ==========================================================================
  // Decode helpers.
  function automatic logic inRange24(input logic [23:0] a, input logic [23:0] lo, input logic [23:0] hi);
    inRange24 = (a >= lo) && (a <= hi);
  endfunction

  function automatic logic inRange10(input logic [9:0] a, input logic [9:0] lo, input logic [9:0] hi);
    inRange10 = (a >= lo) && (a <= hi);
  endfunction

  // ==========================================================================
  // Register state.
  hdsc_ctrl_t ctrl;
  hdsc_ctrl_t next_ctrl;
  logic [7:0] windowMap;
  logic [7:0] next_windowMap;
  logic [7:0] semFlags;
  logic [7:0] next_semFlags;
  logic [7:0] next_hostIoRdata;
  logic [7:0] next_dspIoRdata;

  logic hostSemHit;
  logic dspSemHit;
  logic [2:0] hostSemIdx;
  logic [2:0] dspSemIdx;
  logic [7:0] ctrlBits;
  logic [3:0] lowNib;
  logic [3:0] highNib;

  assign hostSemHit = inRange10(hostIo.addr, HOST_SEM_BASE, HOST_SEM_LAST);
  assign dspSemHit = inRange24(dspIo.addr, DSP_SEM_BASE, DSP_SEM_LAST);
  assign hostSemIdx = hostIo.addr[2:0];
  assign dspSemIdx = dspIo.addr[2:0];
  assign ctrlBits = ctrl;

  // ==========================================================================
  // Next-state logic for control, map and semaphores.
  always_comb begin
    lowNib = ctrlBits[3:0];
    highNib = ctrlBits[7:4];
    next_windowMap = windowMap;
    next_semFlags = semFlags;
    if (hostIo.wr && hostIo.addr == HOST_CTRL_ADDR) begin
      lowNib = hostIo.wdata[3:0];
    end
    if (dspIo.wr && dspIo.addr == DSP_CTRL_ADDR) begin
      highNib = dspIo.wdata[7:4];
    end
    if (hostIo.wr && hostIo.addr == HOST_MAP_ADDR) begin
      next_windowMap = hostIo.wdata;
    end
    // Processor write lands first so a same-cycle host write to the same flag wins.
    if (dspIo.wr && dspSemHit) begin
      next_semFlags[dspSemIdx] = dspIo.wdata[0];
    end
    if (hostIo.wr && hostSemHit) begin
      next_semFlags[hostSemIdx] = hostIo.wdata[0];
    end
    next_ctrl = {highNib, lowNib};
    if (rst || hostResetIn) begin
      next_ctrl = (next_ctrl & CTRL_DSP_MASK) | {4'h0, NIBBLE_RESET};
    end
    // The board soft reset counts as a reset applied to the processor.
    if (rst || dspResetIn || !ctrl.boardSoftResetN) begin
      next_ctrl = (next_ctrl & CTRL_HOST_MASK) | {NIBBLE_RESET, 4'h0};
    end
    // The arm clears follow the resets, so a reset that drops an arm bit also drops its interrupt.
    // A disarmed interrupt is held cleared; after re-arming, the interrupt bit must be written to 1 again.
    if (!next_ctrl.hostToDspIrqArm) begin
      next_ctrl.hostToDspIrq = 1'b0;
    end
    if (!next_ctrl.dspToHostIrqArm) begin
      next_ctrl.dspToHostIrq = 1'b0;
    end
    if (rst || hostResetIn) begin
      next_windowMap = MAP_RESET;
    end
    if (rst) begin
      next_semFlags = SEM_RESET;
    end
  end

  // ==========================================================================
  // Read data; the mapping register is write only and reads as zero.
  always_comb begin
    next_hostIoRdata = READ_ZERO;
    next_dspIoRdata = READ_ZERO;
    if (hostIo.rd && hostIo.addr == HOST_CTRL_ADDR) begin
      next_hostIoRdata = ctrlBits;
    end else if (hostIo.rd && hostSemHit) begin
      next_hostIoRdata = {7'h00, semFlags[hostSemIdx]};
    end
    if (dspIo.rd && dspIo.addr == DSP_CTRL_ADDR) begin
      next_dspIoRdata = ctrlBits;
    end else if (dspIo.rd && dspSemHit) begin
      next_dspIoRdata = {7'h00, semFlags[dspSemIdx]};
    end
  end

  always_ff @(posedge ref_clk) begin
    ctrl <= next_ctrl;
    windowMap <= next_windowMap;
    semFlags <= next_semFlags;
    hostIoRdata <= rst ? READ_ZERO : next_hostIoRdata;
    dspIoRdata <= rst ? READ_ZERO : next_dspIoRdata;
  end

  // ==========================================================================
  // Registered control levels so the far side never sees a decode glitch.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      processorIrqInputZero <= 1'b0;
      hostIrqRequest <= 1'b0;
      boardSoftResetN <= 1'b0;
      expSramHighAddr <= 1'b0;
    end else begin
      processorIrqInputZero <= ctrl.hostToDspIrq && ctrl.hostToDspIrqArm;
      hostIrqRequest <= ctrl.dspToHostIrq && ctrl.dspToHostIrqArm;
      boardSoftResetN <= ctrl.boardSoftResetN;
      expSramHighAddr <= ctrl.bankSelect;
    end
  end

  // ==========================================================================
  // Address decodes. Semaphores play no part here, so software alone coordinates.
  assign hostWindowSelect = hostMemReq && ctrl.windowEnable
    && (hostMemAddr[WIN_PAGE_MSB:WIN_PAGE_LSB] == windowMap);
  assign dspMemSelect = inRange24(dspIo.addr, DSP_MEM_BASE, DSP_MEM_LAST);
  assign bootRomSelect = ctrl.memSwap ? inRange24(primAddr, PRIM_HIGH_BASE, PRIM_HIGH_LAST)
    : inRange24(primAddr, PRIM_LOW_BASE, PRIM_LOW_LAST);
  assign sramBank0Select = ctrl.memSwap ? inRange24(primAddr, PRIM_LOW_BASE, PRIM_LOW_LAST)
    : inRange24(primAddr, PRIM_HIGH_BASE, PRIM_HIGH_LAST);

  // ==========================================================================
  // Checks.
  property p_irqZero;
    @(posedge ref_clk) disable iff (rst)
    (ctrl.hostToDspIrq && ctrl.hostToDspIrqArm) |=> processorIrqInputZero;
  endproperty
  a_irqZero: assert property (p_irqZero) else $error("processor interrupt not raised");

  property p_h2dArm;
    @(posedge ref_clk) disable iff (rst)
    !ctrl.hostToDspIrqArm |-> !ctrl.hostToDspIrq ##1 !processorIrqInputZero;
  endproperty
  a_h2dArm: assert property (p_h2dArm) else $error("disarmed host interrupt leaked");

  property p_hostIrq;
    @(posedge ref_clk) disable iff (rst)
    (ctrl.dspToHostIrq && ctrl.dspToHostIrqArm) |=> hostIrqRequest;
  endproperty
  a_hostIrq: assert property (p_hostIrq) else $error("host interrupt not raised");

  property p_d2hArm;
    @(posedge ref_clk) disable iff (rst)
    !ctrl.dspToHostIrqArm |-> !ctrl.dspToHostIrq ##1 !hostIrqRequest;
  endproperty
  a_d2hArm: assert property (p_d2hArm) else $error("disarmed processor interrupt leaked");

  property p_hostWrite;
    @(posedge ref_clk) disable iff (rst || hostResetIn || dspResetIn)
    (hostIo.wr && hostIo.addr == HOST_CTRL_ADDR && hostIo.wdata[1] && ctrl.boardSoftResetN)
      |=> ctrlBits[3:2] == $past(hostIo.wdata[3:2]);
  endproperty
  a_hostWrite: assert property (p_hostWrite) else $error("host control write lost");

  property p_hostReset;
    @(posedge ref_clk) hostResetIn |=> ctrlBits[3:0] == 4'h0;
  endproperty
  a_hostReset: assert property (p_hostReset) else $error("host reset left lower nibble");

  property p_softReset;
    @(posedge ref_clk) disable iff (rst)
    !ctrl.boardSoftResetN |=> !boardSoftResetN && ctrlBits[7:4] == 4'h0;
  endproperty
  a_softReset: assert property (p_softReset) else $error("soft reset not held");

  property p_bank;
    @(posedge ref_clk) disable iff (rst)
    ctrl.bankSelect |=> expSramHighAddr;
  endproperty
  a_bank: assert property (p_bank) else $error("bank select not driven");

  property p_swap;
    @(posedge ref_clk) disable iff (rst)
    (inRange24(primAddr, PRIM_LOW_BASE, PRIM_LOW_LAST)) |-> (bootRomSelect != ctrl.memSwap);
  endproperty
  a_swap: assert property (p_swap) else $error("primary decode swap wrong");

  property p_window;
    @(posedge ref_clk) disable iff (rst)
    hostWindowSelect |-> ctrl.windowEnable && hostMemAddr[WIN_PAGE_MSB:WIN_PAGE_LSB] == windowMap;
  endproperty
  a_window: assert property (p_window) else $error("window decode mismatch");

  property p_semWrite;
    @(posedge ref_clk) disable iff (rst)
    (hostIo.wr && hostSemHit) |=> semFlags[$past(hostSemIdx)] == $past(hostIo.wdata[0]);
  endproperty
  a_semWrite: assert property (p_semWrite) else $error("semaphore write lost");

  c_hostIrq: cover property (@(posedge ref_clk) disable iff (rst) $rose(hostIrqRequest));
  c_dspIrq: cover property (@(posedge ref_clk) disable iff (rst) $rose(processorIrqInputZero));
  c_window: cover property (@(posedge ref_clk) disable iff (rst) hostWindowSelect);
  c_swap: cover property (@(posedge ref_clk) disable iff (rst) ctrl.memSwap && sramBank0Select);

endmodule // hdsc_shared_control

// ### tb/hdsc_host_model.sv
// Behavioural model of the host I/O and memory bus that faces the shared control block.
`timescale 1ns/1ps

module hdsc_host_model
  import hdsc_pkg::*;
(
  // Clock and read data.
  input wire logic ref_clk,
  input wire logic [7:0] hostIoRdata,
  // Host cycles.
  output hdsc_host_io_t hostIo,
  output logic hostMemReq,
  output logic [19:0] hostMemAddr
);
  initial begin
    hostIo = '0;
    hostMemReq = 1'b0;
    hostMemAddr = '0;
  end

  // ==========================================================================
  // One I/O cycle; released lines show the inverse so stale values never look valid.
  task automatic io(input logic w, input logic [9:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge ref_clk);
    #1;
    hostIo.addr = a;
    hostIo.wr = w;
    hostIo.rd = !w;
    hostIo.wdata = d;
    @(posedge ref_clk);
    #1;
    q = hostIoRdata;
    hostIo.wr = 1'b0;
    hostIo.rd = 1'b0;
    hostIo.addr = ~a;
    hostIo.wdata = ~d;
  endtask

  task automatic mem(input logic req, input logic [19:0] a);
    @(posedge ref_clk);
    #1;
    hostMemReq = req;
    hostMemAddr = a;
  endtask
endmodule // hdsc_host_model

// ### tb/test_host_dsp_shared_control.sv
// Self-checking testbench for the host/processor shared control block.
`timescale 1ns/1ps

module test_host_dsp_shared_control
  import hdsc_pkg::*;
;
  logic ref_clk, rst, hostResetIn, dspResetIn, hostMemReq;
  hdsc_host_io_t hostIo;
  hdsc_dsp_io_t dspIo;
  logic [7:0] hostIoRdata, dspIoRdata, rd;
  logic [19:0] hostMemAddr;
  logic [23:0] primAddr;
  logic hostWindowSelect, dspMemSelect, bootRomSelect, sramBank0Select;
  logic processorIrqInputZero, hostIrqRequest, boardSoftResetN, expSramHighAddr;
  int error_cnt, compares;

  hdsc_shared_control uut (.ref_clk(ref_clk), .rst(rst), .hostResetIn(hostResetIn), .dspResetIn(dspResetIn),
    .hostIo(hostIo), .hostIoRdata(hostIoRdata), .hostMemReq(hostMemReq), .hostMemAddr(hostMemAddr),
    .hostWindowSelect(hostWindowSelect), .dspIo(dspIo), .dspIoRdata(dspIoRdata), .dspMemSelect(dspMemSelect),
    .primAddr(primAddr), .bootRomSelect(bootRomSelect), .sramBank0Select(sramBank0Select),
    .processorIrqInputZero(processorIrqInputZero), .hostIrqRequest(hostIrqRequest),
    .boardSoftResetN(boardSoftResetN), .expSramHighAddr(expSramHighAddr));

  hdsc_host_model host (.ref_clk(ref_clk), .hostIoRdata(hostIoRdata), .hostIo(hostIo),
    .hostMemReq(hostMemReq), .hostMemAddr(hostMemAddr));

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // ==========================================================================
  // Shared tasks.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic dsp(input logic w, input logic [23:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1;
    dspIo.addr = a;
    dspIo.wr = w;
    dspIo.rd = !w;
    dspIo.wdata = d;
    @(posedge ref_clk);
    #1;
    rd = dspIoRdata;
    dspIo.wr = 1'b0;
    dspIo.rd = 1'b0;
    dspIo.addr = ~a;
    dspIo.wdata = ~d;
  endtask

  task automatic hw(input logic [9:0] a, input logic [7:0] d);
    host.io(1'b1, a, d, rd);
  endtask

  task automatic hr(input logic [9:0] a);
    host.io(1'b0, a, 8'h00, rd);
  endtask

  // Registered outputs trail the control register by one cycle, so allow two.
  task automatic settle;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask

  task automatic win(input logic req, input logic [19:0] a, input logic exp);
    host.mem(req, a);
    #1;
    chk(hostWindowSelect, exp);
  endtask

  task automatic dmem(input logic [23:0] a, input logic exp);
    @(posedge ref_clk);
    #1;
    dspIo.addr = a;
    #1;
    chk(dspMemSelect, exp);
  endtask

  // ==========================================================================
  // Scenarios.
  task automatic t_reset;
    hr(HOST_CTRL_ADDR);
    chk(rd, 8'h00);
    chk(boardSoftResetN, 1'b0);
    dsp(1'b1, DSP_CTRL_ADDR, 8'hf0);
    dsp(1'b0, DSP_CTRL_ADDR, 8'h00);
    chk(rd, 8'h00);
    $display("test reset done");
  endtask

  task automatic t_owner;
    hw(HOST_CTRL_ADDR, 8'hff);
    hr(HOST_CTRL_ADDR);
    chk(rd, 8'h0e);
    settle;
    chk(boardSoftResetN, 1'b1);
    dsp(1'b1, DSP_CTRL_ADDR, 8'hff);
    dsp(1'b0, DSP_CTRL_ADDR, 8'h00);
    chk(rd, 8'hfe);
    settle;
    chk(hostIrqRequest, 1'b1);
    chk(processorIrqInputZero, 1'b0);
    $display("test ownership done");
  endtask

  task automatic t_irq;
    hw(HOST_CTRL_ADDR, 8'h0f);
    settle;
    chk(processorIrqInputZero, 1'b1);
    dsp(1'b1, DSP_CTRL_ADDR, 8'hdf);
    hr(HOST_CTRL_ADDR);
    chk(rd, 8'hde);
    settle;
    chk(processorIrqInputZero, 1'b0);
    hw(HOST_CTRL_ADDR, 8'h0d);
    hr(HOST_CTRL_ADDR);
    chk(rd, 8'hcc);
    hw(HOST_CTRL_ADDR, 8'h0e);
    settle;
    chk(hostIrqRequest, 1'b0);
    dsp(1'b1, DSP_CTRL_ADDR, 8'hf0);
    settle;
    chk(hostIrqRequest, 1'b1);
    $display("test interrupts done");
  endtask

  task automatic t_window;
    hw(HOST_MAP_ADDR, 8'ha5);
    hr(HOST_MAP_ADDR);
    chk(rd, 8'h00);
    win(1'b1, 20'ha_5000, 1'b1);
    win(1'b1, 20'ha_5fff, 1'b1);
    win(1'b1, 20'ha_4fff, 1'b0);
    win(1'b1, 20'ha_6000, 1'b0);
    win(1'b0, 20'ha_5000, 1'b0);
    hw(HOST_CTRL_ADDR, 8'h0a);
    win(1'b1, 20'ha_5000, 1'b0);
    hw(HOST_CTRL_ADDR, 8'h0e);
    $display("test window done");
  endtask

  task automatic t_decode;
    for (int s = 0; s < 2; s++) begin
      dsp(1'b1, DSP_CTRL_ADDR, {s[0], s[0], 6'h30});
      settle;
      chk(expSramHighAddr, s[0]);
      primAddr = PRIM_LOW_LAST;
      #1;
      chk({bootRomSelect, sramBank0Select}, {6'h00, !s[0], s[0]});
      primAddr = PRIM_HIGH_BASE;
      #1;
      chk({bootRomSelect, sramBank0Select}, {6'h00, s[0], !s[0]});
    end
    dmem(DSP_MEM_BASE, 1'b1);
    dmem(DSP_MEM_LAST, 1'b1);
    dmem(DSP_MEM_LAST + 24'h00_0001, 1'b0);
    $display("test decode done");
  endtask

  task automatic t_sem;
    hw(HOST_SEM_LAST, 8'hff);
    hr(HOST_SEM_LAST);
    chk(rd, 8'h01);
    dsp(1'b0, DSP_SEM_LAST, 8'h00);
    chk(rd, 8'h01);
    hr(HOST_SEM_BASE);
    chk(rd, 8'h00);
    dmem(DSP_MEM_BASE, 1'b1);
    dsp(1'b1, DSP_SEM_LAST, 8'hfe);
    hr(HOST_SEM_LAST);
    chk(rd, 8'h00);
    $display("test semaphores done");
  endtask

  task automatic t_resets;
    hw(HOST_CTRL_ADDR, 8'h0f);
    @(posedge ref_clk);
    #1;
    dspResetIn = 1'b1;
    @(posedge ref_clk);
    #1;
    dspResetIn = 1'b0;
    hr(HOST_CTRL_ADDR);
    chk(rd, 8'h0e);
    chk(processorIrqInputZero, 1'b0);
    chk(hostIrqRequest, 1'b0);
    hostResetIn = 1'b1;
    @(posedge ref_clk);
    #1;
    hostResetIn = 1'b0;
    hr(HOST_CTRL_ADDR);
    chk(rd, 8'h00);
    settle;
    chk(boardSoftResetN, 1'b0);
    $display("test resets done");
  endtask

  // ==========================================================================
  // Verdict and main sequence.
  task automatic end_of_test;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // The whole run needs about a hundred cycles; this limit leaves wide margin.
  initial begin
    #50000;
    error_cnt++;
    $display("BAD %0t watchdog expired", $time);
    end_of_test;
  end

  initial begin
    rst = 1'b1;
    hostResetIn = 1'b0;
    dspResetIn = 1'b0;
    dspIo = '0;
    primAddr = '0;
    error_cnt = 0;
    compares = 0;
    repeat (10) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    t_reset;
    t_owner;
    t_irq;
    t_window;
    t_decode;
    t_sem;
    t_resets;
    end_of_test;
  end
endmodule // test_host_dsp_shared_control
